/* hdl/gtf_pkg.sv */
// package: register map, field layout and types of the gate timing feedback bank
package gtf_pkg;

  // ---------------------------------------------------------------
  // register addresses (5-bit serial register address)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_PWM1_EFFECTIVE_DELAYS = 5'h14;
  localparam logic [4:0] ADDR_PWM2_EFFECTIVE_DELAYS = 5'h15;
  localparam logic [4:0] ADDR_PWM3_EFFECTIVE_DELAYS = 5'h16;
  localparam logic [4:0] ADDR_PWM1_EDGE_TIMES       = 5'h17;
  localparam logic [4:0] ADDR_PWM2_EDGE_TIMES       = 5'h18;
  localparam logic [4:0] ADDR_PWM3_EDGE_TIMES       = 5'h19;
  // status word holding bridge output level and mapping error flags
  localparam logic [4:0] ADDR_BRIDGE_STATUS         = 5'h13;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int          HI_BYTE_LSB        = 8;
  localparam int          LO_BYTE_LSB        = 0;
  localparam int          OUT_LEVEL_BIT      = 0;
  localparam int          MAP_ERR_LSB        = 8;
  localparam logic [15:0] TIMING_RESET_VALUE = 16'h0000;
  localparam logic [15:0] STATUS_RESET_VALUE = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ      = 16'h0000;

  // one count of every timing field, in picoseconds (62.5 ns)
  localparam int          TIME_LSB_PS        = 62500;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF_A = 2'b00,
    MODE_PWM_A = 2'b01,
    MODE_PWM_B = 2'b10,
    MODE_OFF_B = 2'b11
  } gtf_mode_t;

  // one channel's measured timing, delivered by the measurement unit
  typedef struct packed {
    logic [7:0] turnoff_delay;
    logic [7:0] turnon_delay;
    logic [7:0] fall_time;
    logic [7:0] rise_time;
  } gtf_meas_t;

  // register access request: read/write strobes and address
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
  } gtf_req_t;

endpackage

/* hdl/gtf_regs.sv */
// gate timing feedback status bank: bridge output level, mapping errors, timings
`timescale 1ns/1ps

// Behaviour
// - bridge1 level high when node near reference
// - comparison uses bridge's own drain-source threshold
// - level reads 0 in modes 01/10
// - mapping error clears when <=1 mapped or channel inactive
// - pwm1 delays 0x14, off high, on low
// - pwm2 delays 0x15, same layout, reset 0
// - pwm3 delays 0x16, same layout, reset 0
// - pwm1 edge times: fall high, rise low
// - pwm2 edge times: fall high, rise low
// - pwm3 edge times: fall high, rise low
// - mapping error 1 when >1 active mapped
module gtf_regs #(
  parameter int NUM_CH  = 3, // pwm channels
  parameter int NUM_HB  = 8  // half-bridges
) (
  input  wire logic                 clk_sys_i,          // 25 mhz system clock
  input  wire logic                 rst_i,              // synchronous reset, active high
  // register port
  input  wire gtf_pkg::gtf_req_t    req_i,              // read/write strobe and address
  output logic [15:0]               rd_data_o,          // read data, valid with rd_valid_o
  output logic                      rd_valid_o,         // one-cycle pulse per read
  // output level monitor of bridge 1
  input  wire logic                 node_near_drain_i,  // pin: |drain - node| < threshold
  input  wire logic                 node_near_sense_i,  // pin: |sense - node| < threshold
  input  wire logic                 bridge1_reference_select_i, // 0 drain, 1 sense input
  input  wire logic [1:0]           bridge1_drive_mode_i,       // bridge 1 mode field
  // pwm mapping
  input  wire logic [NUM_CH-1:0]    pwm_active_i,       // channel activated
  input  wire logic [NUM_HB*2-1:0]  pwm_channel_mapping_i, // per bridge: 0 none, 1..3 ch
  // measured timing per channel
  input  wire gtf_pkg::gtf_meas_t [NUM_CH-1:0] meas_i,  // latest measurement
  input  wire logic [NUM_CH-1:0]    meas_valid_i,       // one-cycle pulse per new result
  output logic [NUM_HB-1:0]         bridge_pwm_mapping_error_o, // per-bridge error flags
  output logic                      bridge1_output_level_o      // bridge 1 level bit
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] near_meta_ff;
  logic [1:0] near_sync_ff;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      near_meta_ff <= 2'h0;
      near_sync_ff <= 2'h0;
    end else begin
      near_meta_ff <= {node_near_sense_i, node_near_drain_i};
      near_sync_ff <= near_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // bridge 1 output level
  // ---------------------------------------------------------------
  // the analogue comparators already use this bridge's own threshold;
  // we only pick which comparator answers
  logic nxt_level;
  logic level_ff;

  always_comb begin
    nxt_level = 1'b0;
    unique case (gtf_pkg::gtf_mode_t'(bridge1_drive_mode_i))
      gtf_pkg::MODE_OFF_A,
      gtf_pkg::MODE_OFF_B: begin
        nxt_level = bridge1_reference_select_i ? near_sync_ff[1]
                                               : near_sync_ff[0];
      end
      gtf_pkg::MODE_PWM_A,
      gtf_pkg::MODE_PWM_B: begin
        nxt_level = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
    end
  end

  // ---------------------------------------------------------------
  // pwm mapping error per half-bridge
  // ---------------------------------------------------------------
  logic [NUM_HB-1:0] map_err_ff;

  // a bridge has a single channel field, so "more than one" is counted over
  // all active channels whose mapping is shared by this bridge and another
  genvar hb;
  generate
    for (hb = 0; hb < NUM_HB; hb++) begin : g_hb
      // every bridge may share one channel, so the count must reach NUM_HB
      // without wrapping back below two
      localparam int CNT_W = $clog2(NUM_HB + 1);
      logic [1:0]       sel;
      logic [CNT_W-1:0] cnt;
      assign sel = pwm_channel_mapping_i[hb*2 +: 2];
      always_comb begin
        cnt = '0;
        for (int c = 0; c < NUM_CH; c++) begin
          if (pwm_active_i[c] && sel == 2'(c + 1)) begin
            cnt = cnt + CNT_W'(1);
          end
        end
        for (int o = 0; o < NUM_HB; o++) begin
          if (o != hb && sel != 2'h0 && pwm_channel_mapping_i[o*2 +: 2] == sel
              && pwm_active_i[sel - 2'h1]) begin
            cnt = cnt + CNT_W'(1);
          end
        end
      end
      // flag follows the count: it stays set while two or more remain
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          map_err_ff[hb] <= 1'b0;
        end else begin
          map_err_ff[hb] <= (cnt > CNT_W'(1));
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // timing capture
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0][15:0] delay_ff;
  logic [NUM_CH-1:0][15:0] edge_ff;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          delay_ff[ch] <= gtf_pkg::TIMING_RESET_VALUE;
          edge_ff[ch]  <= gtf_pkg::TIMING_RESET_VALUE;
        end else if (meas_valid_i[ch]) begin
          delay_ff[ch] <= {meas_i[ch].turnoff_delay, meas_i[ch].turnon_delay};
          edge_ff[ch]  <= {meas_i[ch].fall_time, meas_i[ch].rise_time};
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // register words as the host sees them
  // ---------------------------------------------------------------
  logic [15:0] pwm1_effective_delays;
  logic [15:0] pwm2_effective_delays;
  logic [15:0] pwm3_effective_delays;
  logic [15:0] pwm1_edge_times;
  logic [15:0] pwm2_edge_times;
  logic [15:0] pwm3_edge_times;
  logic [15:0] bridge_status_word;

  assign pwm1_effective_delays = delay_ff[0];
  assign pwm2_effective_delays = delay_ff[1];
  assign pwm3_effective_delays = delay_ff[2];
  assign pwm1_edge_times       = edge_ff[0];
  assign pwm2_edge_times       = edge_ff[1];
  assign pwm3_edge_times       = edge_ff[2];
  // unused status bits between the level bit and the error flags read 0
  assign bridge_status_word    = {map_err_ff, 7'h00, level_ff};

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  // writes are decoded nowhere: every register here is status only
  logic [15:0] nxt_rd_data;
  logic [15:0] rd_data_ff;
  logic        rd_valid_ff;

  always_comb begin
    nxt_rd_data = gtf_pkg::UNMAPPED_READ;
    unique case (req_i.addr)
      gtf_pkg::ADDR_PWM1_EFFECTIVE_DELAYS: nxt_rd_data = pwm1_effective_delays;
      gtf_pkg::ADDR_PWM2_EFFECTIVE_DELAYS: nxt_rd_data = pwm2_effective_delays;
      gtf_pkg::ADDR_PWM3_EFFECTIVE_DELAYS: nxt_rd_data = pwm3_effective_delays;
      gtf_pkg::ADDR_PWM1_EDGE_TIMES:       nxt_rd_data = pwm1_edge_times;
      gtf_pkg::ADDR_PWM2_EDGE_TIMES:       nxt_rd_data = pwm2_edge_times;
      gtf_pkg::ADDR_PWM3_EDGE_TIMES:       nxt_rd_data = pwm3_edge_times;
      gtf_pkg::ADDR_BRIDGE_STATUS:         nxt_rd_data = bridge_status_word;
      default: nxt_rd_data = gtf_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_ff  <= gtf_pkg::STATUS_RESET_VALUE;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= req_i.rd;
      if (req_i.rd) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  assign rd_data_o                  = rd_data_ff;
  assign rd_valid_o                 = rd_valid_ff;
  assign bridge_pwm_mapping_error_o = map_err_ff;
  assign bridge1_output_level_o     = level_ff;

endmodule // gtf_regs

/* bench/gtf_regs_checker.sv */
// checker: port-level assertions for the timing feedback bank
`timescale 1ns/1ps
module gtf_regs_checker #(parameter int NUM_CH = 3, parameter int NUM_HB = 8) (
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  input wire gtf_pkg::gtf_req_t   req_i,
  input wire logic [15:0]         rd_data_o,
  input wire logic                rd_valid_o,
  input wire logic                node_near_drain_i,
  input wire logic                node_near_sense_i,
  input wire logic                bridge1_reference_select_i,
  input wire logic [1:0]          bridge1_drive_mode_i,
  input wire logic [NUM_CH-1:0]   pwm_active_i,
  input wire logic [NUM_HB*2-1:0] pwm_channel_mapping_i,
  input wire logic [NUM_HB-1:0]   bridge_pwm_mapping_error_o,
  input wire logic                bridge1_output_level_o
);
  wire [NUM_HB*2-1:0] m = pwm_channel_mapping_i;
  wire off_mode = bridge1_drive_mode_i inside {2'h0, 2'h3};
  logic [NUM_HB-1:0] exp_err;
  always_comb begin
    exp_err = '0;
    for (int b = 0; b < NUM_HB; b++)
      for (int o = 0; o < NUM_HB; o++)
        if (o != b && m[2*b+:2] != 2'h0 && m[2*o+:2] == m[2*b+:2] && pwm_active_i[m[2*b+:2]-1])
          exp_err[b] = 1'b1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // three samples cover the two-stage pin synchroniser plus the level register
  sequence drain_hi_s;
    (off_mode && !bridge1_reference_select_i && node_near_drain_i)[*3];
  endsequence
  sequence sense_lo_s;
    (off_mode && bridge1_reference_select_i && !node_near_sense_i)[*3];
  endsequence
  a_read_answer: assert property (req_i.rd |=> rd_valid_o)
    else $error("read not answered");
  a_write_silent: assert property (req_i.wr && !req_i.rd |=> !rd_valid_o && $stable(rd_data_o))
    else $error("write disturbed read port");
  a_data_holds: assert property (!req_i.rd |=> $stable(rd_data_o))
    else $error("read data changed without read");
  a_level_drain: assert property (drain_hi_s |=> bridge1_output_level_o)
    else $error("level low with node near drain");
  a_level_sense: assert property (sense_lo_s |=> !bridge1_output_level_o)
    else $error("level high with node far from sense");
  a_mode_low: assert property (!off_mode |=> !bridge1_output_level_o)
    else $error("level high in drive mode");
  a_map_error: assert property (!$past(rst_i) |-> bridge_pwm_mapping_error_o == $past(exp_err))
    else $error("mapping error flags wrong");
  a_unmapped_zero: assert property (req_i.rd && req_i.addr > 5'h19 |=> rd_data_o == 16'h0000)
    else $error("unmapped read not zero");
endmodule // gtf_regs_checker
bind gtf_regs gtf_regs_checker #(.NUM_CH(NUM_CH), .NUM_HB(NUM_HB)) u_chk (.clk_sys_i, .rst_i,
  .req_i, .rd_data_o, .rd_valid_o, .node_near_drain_i, .node_near_sense_i,
  .bridge1_reference_select_i, .bridge1_drive_mode_i, .pwm_active_i, .pwm_channel_mapping_i,
  .bridge_pwm_mapping_error_o, .bridge1_output_level_o);

/* bench/gtf_host.sv */
// host model: issues register accesses on the request port
`timescale 1ns/1ps
module gtf_host (
  input  wire logic        clk_sys_i,  // system clock
  input  wire logic [15:0] rd_data_i,  // answer data
  input  wire logic        rd_valid_i, // answer strobe
  output gtf_pkg::gtf_req_t req_o      // request
);
  initial req_o = '0;
  // a missing answer returns x, so it can never pass a compare
  task automatic acc(input logic rd, input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys_i) req_o = {rd, !rd, a};
    // the answer strobe stands for one cycle only: take it before it falls
    @(negedge clk_sys_i) d = rd_valid_i ? rd_data_i : 'x;
    req_o = '0;
  endtask
endmodule // gtf_host

/* bench/testbench.sv */
// testbench: reference model comparison of the timing feedback bank
`timescale 1ns/1ps
module testbench;
  logic clk_sys_i, rst_i, drain, sense, sel, rvalid, lvl, e;
  logic [1:0] mode;
  logic [2:0] act, vld;
  logic [7:0] err;
  logic [15:0] map, rdata, d;
  gtf_pkg::gtf_req_t req;
  gtf_pkg::gtf_meas_t [2:0] meas;
  int fail_count = 0, compares = 0, cyc = 0;
  int mdl [6];
  gtf_regs DUT (.clk_sys_i, .rst_i, .req_i(req), .rd_data_o(rdata), .rd_valid_o(rvalid),
    .node_near_drain_i(drain), .node_near_sense_i(sense), .bridge1_reference_select_i(sel),
    .bridge1_drive_mode_i(mode), .pwm_active_i(act), .pwm_channel_mapping_i(map),
    .meas_i(meas), .meas_valid_i(vld), .bridge_pwm_mapping_error_o(err),
    .bridge1_output_level_o(lvl));
  gtf_host host (.clk_sys_i, .rd_data_i(rdata), .rd_valid_i(rvalid), .req_o(req));
  initial begin
    clk_sys_i = 0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  function automatic logic [7:0] exp_err(logic [15:0] m, logic [2:0] a);
    exp_err = 0;
    for (int b = 0; b < 8; b++)
      for (int o = 0; o < 8; o++)
        if (o != b && m[2*b+:2] != 0 && m[2*o+:2] == m[2*b+:2] && a[m[2*b+:2]-1])
          exp_err[b] = 1;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {rst_i, drain, sense, sel, mode, act, map, meas, vld} = '1;
    {drain, sense, sel, mode, act, map, meas, vld} = '0;
    void'($urandom(2));
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i) rst_i = 0;
    for (int a = 'h13; a <= 'h1f; a++) begin
      host.acc(1, a[4:0], d);
      chk(d, 16'h0000);
    end
    repeat (4) begin
      @(negedge clk_sys_i);
      meas = {$urandom, $urandom, $urandom};
      vld = 3'($urandom);
      for (int c = 0; c < 3; c++)
        if (vld[c]) begin
          mdl[c] = {meas[c].turnoff_delay, meas[c].turnon_delay};
          mdl[c+3] = {meas[c].fall_time, meas[c].rise_time};
        end
      @(negedge clk_sys_i) vld = 0;
      meas = {$urandom, $urandom, $urandom};
      for (int a = 0; a < 6; a++) begin
        host.acc(0, 5'h14 + a[4:0], d);
        host.acc(1, 5'h14 + a[4:0], d);
        chk(d, mdl[a][15:0]);
      end
    end
    for (int i = 0; i < 32; i++) begin
      @(negedge clk_sys_i);
      {mode, sel, drain, sense} = i[4:0];
      map = 16'($urandom);
      act = 3'($urandom);
      repeat (4) @(negedge clk_sys_i);
      e = (mode == 0 || mode == 3) && (sel ? sense : drain);
      chk(lvl, e);
      chk(err, exp_err(map, act));
      host.acc(1, 5'h13, d);
      chk(d, {exp_err(map, act), 7'h00, e});
    end
    // all eight bridges on one active channel, then the channel switched off
    @(negedge clk_sys_i);
    map = 16'h5555;
    act = 3'h1;
    repeat (2) @(negedge clk_sys_i);
    chk(err, 8'hff);
    act = 3'h0;
    repeat (2) @(negedge clk_sys_i);
    chk(err, 8'h00);
    end_of_test();
  end
endmodule // testbench
